// ===== hdl/adr_defs.svh
// constants of the asynchronous dma request channel
`ifndef ADR_DEFS_SVH
`define ADR_DEFS_SVH

// ----------------------------------------------------------------
// request source codes
// ----------------------------------------------------------------
`define ADR_SRC_W 3
`define ADR_SRC_SERIAL_TX 3'h0
`define ADR_SRC_SERIAL_RX 3'h1
`define ADR_SRC_TIMER_CHAN 3'h2
`define ADR_SRC_TIMER_OVF 3'h3
`define ADR_SRC_CONVERTER 3'h4
`define ADR_SRC_COMPARATOR 3'h5
`define ADR_SRC_PIN_BANK_ONE 3'h6
`define ADR_SRC_PIN_BANK_FOUR 3'h7

// ----------------------------------------------------------------
// timer channels and the subset that can request without a clock
// ----------------------------------------------------------------
`define ADR_TIMER_CH_N 6
`define ADR_TIMER_SEL_W 3
`define ADR_TIMER_ASYNC_MASK 6'h03

// ----------------------------------------------------------------
// one-hot state codes and reset values
// ----------------------------------------------------------------
`define ADR_ST_IDLE 4'h1
`define ADR_ST_WAKE 4'h2
`define ADR_ST_XFER 4'h4
`define ADR_ST_RELEASE 4'h8
`define ADR_RST_BIT 1'b0
`define ADR_RST_LP_OK 1'b1

`endif

// ===== hdl/adr_pkg.sv
// types of the asynchronous dma request channel
`include "adr_defs.svh"

package adr_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = `ADR_ST_IDLE,
        ST_WAKE = `ADR_ST_WAKE,
        ST_XFER = `ADR_ST_XFER,
        ST_RELEASE = `ADR_ST_RELEASE
    } chan_state_e;

    // settings of the channel control word; this block acts on all but periodic_gate_select
    typedef struct packed {
        logic chan_enable;
        logic async_request_enable;
        logic cycle_steal;
        logic periodic_gate_select;
        logic [`ADR_SRC_W-1:0] source_select;
        logic [`ADR_TIMER_SEL_W-1:0] timer_chan_select;
    } channel_control_word_s;

    // request inputs of the peripherals
    typedef struct packed {
        logic serial_tx;
        logic serial_rx;
        logic [`ADR_TIMER_CH_N-1:0] timer_chan;
        logic timer_ovf;
        logic conv_complete;
        logic conv_dma_enable;
        logic comparator;
        logic pin_bank_one;
        logic pin_bank_four;
    } periph_req_s;

endpackage

// ===== hdl/adr_request_select.sv
// source multiplexer: selected request level and whether it may arrive clockless
`timescale 1ns/1ns
`default_nettype none
`include "adr_defs.svh"

module adr_request_select
(
    // settings
    input wire adr_pkg::channel_control_word_s cfg,
    // peripherals
    input wire adr_pkg::periph_req_s req,
    // result
    output logic req_level,
    output logic async_capable
);

    logic timer_lvl;
    logic timer_async;
    logic [`ADR_TIMER_CH_N-1:0] async_mask;

    assign timer_lvl = req.timer_chan[cfg.timer_chan_select];
    // only some timer channels reach the wake logic, the rest are clocked only
    assign async_mask = `ADR_TIMER_ASYNC_MASK;
    assign timer_async = async_mask[cfg.timer_chan_select]; // see RULE_06

    always_comb
    begin
        req_level = `ADR_RST_BIT;
        async_capable = 1'b1; // see RULE_05
        case (cfg.source_select)
            `ADR_SRC_SERIAL_TX: req_level = req.serial_tx;
            `ADR_SRC_SERIAL_RX: req_level = req.serial_rx;
            `ADR_SRC_TIMER_CHAN:
            begin
                req_level = timer_lvl;
                async_capable = timer_async; // see RULE_06
            end
            `ADR_SRC_TIMER_OVF: req_level = req.timer_ovf;
            `ADR_SRC_CONVERTER: req_level = req.conv_complete & req.conv_dma_enable; // see RULE_12
            `ADR_SRC_COMPARATOR: req_level = req.comparator;
            `ADR_SRC_PIN_BANK_ONE: req_level = req.pin_bank_one;
            `ADR_SRC_PIN_BANK_FOUR: req_level = req.pin_bank_four;
            default: req_level = `ADR_RST_BIT;
        endcase
    end

endmodule
`default_nettype wire

// ===== hdl/async_dma_request_channel.sv
// dma channel request front end with clockless request acceptance and wake
`timescale 1ns/1ns
`default_nettype none
`include "adr_defs.svh"

// Summary of operation
// RULE_01 - async requests accepted only when enable set
// RULE_02 - other settings behave same as synchronous
// RULE_03 - software avoids timer gating in deep sleep
// RULE_04 - cycle-steal: one transfer per trigger
// RULE_05 - eight listed sources may request asynchronously
// RULE_06 - only some timer channels request asynchronously
// RULE_07 - software enables a sleep-surviving peripheral clock
// RULE_08 - disable channel, then peripheral, before reconfiguring
// RULE_09 - peripheral configured as for interrupt use
// RULE_10 - peripheral dma enable, peripheral, then channel
// RULE_11 - enter low power after channel and peripheral
// RULE_12 - converter requests on each completed conversion
// RULE_13 - gated request restores clock, transfers, releases
module async_dma_request_channel
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // channel settings
    input wire adr_pkg::channel_control_word_s CFG,
    // peripheral requests
    input wire adr_pkg::periph_req_s PERIPH_REQ,
    // power manager
    input wire logic CLOCK_GATED,
    input wire logic CLOCK_RUNNING,
    output logic CLOCK_WAKE_REQ,
    output logic LOW_POWER_OK,
    // transfer engine
    output logic XFER_REQ,
    input wire logic XFER_DONE,
    // status
    output logic REQ_PENDING,
    output logic CHANNEL_BUSY
);

    // ----------------------------------------------------------------
    // request selection and acceptance
    // ----------------------------------------------------------------
    logic req_level;
    logic async_capable;
    logic accept;
    logic req_seen_ff;
    logic trig;
    logic pend_set;
    logic pend_clr;
    logic pending_ff;
    adr_pkg::chan_state_e state_ff;
    adr_pkg::chan_state_e nxt_state;
    logic xfer_ff;
    logic wake_ff;
    logic lp_ok_ff;
    logic busy_ff;

    adr_request_select u_select
    (
        .cfg(CFG),
        .req(PERIPH_REQ),
        .req_level(req_level),
        .async_capable(async_capable)
    );

    // periodic gating is not modelled here; software keeps it off in deep sleep
    // while the clock is running the enable bit plays no part
    assign accept = CFG.chan_enable &
                    (!CLOCK_GATED | (CFG.async_request_enable & async_capable)); // see RULE_01
    assign trig = accept & req_level & !req_seen_ff;
    // same mode choice in both operations: edge for cycle-steal, level otherwise
    assign pend_set = CFG.cycle_steal ? trig : (accept & req_level); // see RULE_02
    assign pend_clr = (state_ff == adr_pkg::ST_XFER) & XFER_DONE;

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            req_seen_ff <= `ADR_RST_BIT;
        else
            req_seen_ff <= req_level;
    end

    // a trigger landing with the completion is kept; one landing earlier in the transfer is merged and lost
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            pending_ff <= `ADR_RST_BIT;
        else
            pending_ff <= pend_set | (pending_ff & !pend_clr); // see RULE_04
    end

    // ----------------------------------------------------------------
    // channel sequence
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            adr_pkg::ST_IDLE:
                if (pending_ff)
                    nxt_state = CLOCK_GATED ? adr_pkg::ST_WAKE : adr_pkg::ST_XFER; // see RULE_13
            adr_pkg::ST_WAKE:
                if (CLOCK_RUNNING)
                    nxt_state = adr_pkg::ST_XFER;
            adr_pkg::ST_XFER:
                if (XFER_DONE)
                    nxt_state = wake_ff ? adr_pkg::ST_RELEASE : adr_pkg::ST_IDLE; // see RULE_04
            adr_pkg::ST_RELEASE:
                nxt_state = adr_pkg::ST_IDLE;
            default:
                nxt_state = adr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            state_ff <= adr_pkg::ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            xfer_ff <= `ADR_RST_BIT;
        else
            xfer_ff <= (nxt_state == adr_pkg::ST_XFER);
    end

    // wake stays up from the request until the single transfer has ended
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            wake_ff <= `ADR_RST_BIT;
        else if (state_ff == adr_pkg::ST_IDLE && pending_ff && CLOCK_GATED)
            wake_ff <= 1'b1; // see RULE_13
        else if (state_ff == adr_pkg::ST_RELEASE)
            wake_ff <= `ADR_RST_BIT; // see RULE_13
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            busy_ff <= `ADR_RST_BIT;
        else
            busy_ff <= (nxt_state != adr_pkg::ST_IDLE);
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            lp_ok_ff <= `ADR_RST_LP_OK;
        else
            lp_ok_ff <= (nxt_state == adr_pkg::ST_IDLE) & !pend_set; // see RULE_13
    end

    assign XFER_REQ = xfer_ff;
    assign CLOCK_WAKE_REQ = wake_ff;
    assign LOW_POWER_OK = lp_ok_ff;
    assign REQ_PENDING = pending_ff;
    assign CHANNEL_BUSY = busy_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    sequence s_gated_request;
        state_ff == adr_pkg::ST_IDLE && pending_ff && CLOCK_GATED;
    endsequence

    sequence s_wake_then_xfer;
        CLOCK_WAKE_REQ && !XFER_REQ ##[1:8] CLOCK_RUNNING ##1 XFER_REQ && CLOCK_WAKE_REQ;
    endsequence

    a_gated_no_accept: assert property ( // see RULE_01
        CLOCK_GATED && !CFG.async_request_enable && !pending_ff |=> !pending_ff)
        else $error("request accepted while gated without async enable");

    // own copy of the mask, so the check does not lean on the selector's decode
    logic [`ADR_TIMER_CH_N-1:0] timer_async_mask;
    assign timer_async_mask = `ADR_TIMER_ASYNC_MASK;

    a_timer_subset: assert property ( // see RULE_06
        CLOCK_GATED && CFG.source_select == `ADR_SRC_TIMER_CHAN &&
        !timer_async_mask[CFG.timer_chan_select] && !pending_ff |=> !pending_ff)
        else $error("clocked-only timer channel accepted while gated");

    a_wake_raised: assert property ( // see RULE_13
        s_gated_request |=> CLOCK_WAKE_REQ && !XFER_REQ && !LOW_POWER_OK)
        else $error("gated request did not raise wake");

    a_wake_order: assert property ( // see RULE_13
        s_gated_request ##[1:8] (CLOCK_RUNNING && state_ff == adr_pkg::ST_WAKE)
        |=> XFER_REQ && CLOCK_WAKE_REQ)
        else $error("transfer not started once clock restored");

    a_xfer_hold: assert property ( // see RULE_04
        XFER_REQ && !XFER_DONE |=> XFER_REQ)
        else $error("transfer request dropped before done");

    a_single_steal: assert property ( // see RULE_04
        CFG.cycle_steal && XFER_REQ && XFER_DONE && !trig |=> !XFER_REQ ##1 !XFER_REQ)
        else $error("second transfer without a new trigger");

    a_wake_release: assert property ( // see RULE_13
        XFER_REQ && XFER_DONE && CLOCK_WAKE_REQ |=> CLOCK_WAKE_REQ ##1 !CLOCK_WAKE_REQ ##1 LOW_POWER_OK || pending_ff)
        else $error("wake not released after the transfer");

    a_converter_req: assert property ( // see RULE_12
        CFG.chan_enable && !CLOCK_GATED && CFG.cycle_steal &&
        CFG.source_select == `ADR_SRC_CONVERTER && PERIPH_REQ.conv_complete &&
        PERIPH_REQ.conv_dma_enable && !req_seen_ff |=> pending_ff)
        else $error("completed conversion raised no request");

    a_disabled_quiet: assert property ( // see RULE_02
        !CFG.chan_enable && !pending_ff && state_ff == adr_pkg::ST_IDLE |=> !XFER_REQ ##1 !XFER_REQ)
        else $error("disabled channel started a transfer");

    c_wake_walk: cover property (s_wake_then_xfer);

endmodule
`default_nettype wire

// ===== verification/adr_far_side.sv
// far-side model: transfer engine and power manager of the channel
`timescale 1ns/1ns
`default_nettype none
module adr_far_side
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pace: 1 answers slowly
    input wire logic slow,
    // channel side
    input wire logic xfer_req,
    input wire logic wake_req,
    output logic xfer_done,
    output logic clock_running
);
    logic [2:0] cnt_ff;
    logic [1:0] wcnt_ff;

    // one done pulse per transfer; the guard stops a second pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= 3'h0;
            xfer_done <= 1'b0;
        end
        else if (xfer_req && !xfer_done && cnt_ff >= (slow ? 3'h4 : 3'h0))
        begin
            cnt_ff <= 3'h0;
            xfer_done <= 1'b1;
        end
        else
        begin
            cnt_ff <= (xfer_req && !xfer_done) ? cnt_ff + 3'h1 : 3'h0;
            xfer_done <= 1'b0;
        end
    end

    // clock that survives low power comes back after a wake request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wcnt_ff <= 2'h0;
            clock_running <= 1'b0;
        end
        else if (!wake_req)
        begin
            wcnt_ff <= 2'h0;
            clock_running <= 1'b0;
        end
        else if (wcnt_ff == (slow ? 2'h3 : 2'h1))
            clock_running <= 1'b1;
        else
            wcnt_ff <= wcnt_ff + 2'h1;
    end
endmodule
`default_nettype wire

// ===== verification/async_dma_request_channel_tb_top.sv
// self-checking bench of the asynchronous dma request channel
`timescale 1ns/1ns
`default_nettype none
module async_dma_request_channel_tb_top;
    typedef struct packed {
        logic [2:0] src;
        logic [2:0] tsel;
        logic [13:0] req;
        logic gated;
        logic aen;
        logic exp1;
    } row_s;

    logic clk_sys, reset_n, gated, running, wake, lp_ok, xreq, xdone, pend, busy, slow;
    adr_pkg::channel_control_word_s cfg;
    adr_pkg::periph_req_s preq;
    int bad_count = 0;
    int compares = 0;
    int done_cnt = 0;
    // source, timer channel, request bits, gated, async enable, transfer expected
    row_s rows [14] = '{
        '{3'h0, 3'h0, 14'h2000, 1'b1, 1'b1, 1'b1}, '{3'h1, 3'h0, 14'h1000, 1'b1, 1'b1, 1'b1},
        '{3'h2, 3'h0, 14'h0040, 1'b1, 1'b1, 1'b1}, '{3'h2, 3'h1, 14'h0080, 1'b1, 1'b1, 1'b1},
        '{3'h2, 3'h2, 14'h0100, 1'b1, 1'b1, 1'b0}, '{3'h2, 3'h2, 14'h0100, 1'b0, 1'b1, 1'b1},
        '{3'h3, 3'h0, 14'h0020, 1'b1, 1'b1, 1'b1}, '{3'h4, 3'h0, 14'h0010, 1'b0, 1'b1, 1'b0},
        '{3'h4, 3'h0, 14'h0018, 1'b1, 1'b1, 1'b1}, '{3'h5, 3'h0, 14'h0004, 1'b1, 1'b1, 1'b1},
        '{3'h6, 3'h0, 14'h0002, 1'b1, 1'b1, 1'b1}, '{3'h7, 3'h0, 14'h0001, 1'b1, 1'b1, 1'b1},
        '{3'h7, 3'h0, 14'h0001, 1'b1, 1'b0, 1'b0}, '{3'h0, 3'h0, 14'h2000, 1'b0, 1'b0, 1'b1}};

    async_dma_request_channel u_async_dma_request_channel (.CLK_SYS(clk_sys),
        .RESET_N(reset_n), .CFG(cfg), .PERIPH_REQ(preq), .CLOCK_GATED(gated),
        .CLOCK_RUNNING(running), .CLOCK_WAKE_REQ(wake), .LOW_POWER_OK(lp_ok),
        .XFER_REQ(xreq), .XFER_DONE(xdone), .REQ_PENDING(pend), .CHANNEL_BUSY(busy));
    adr_far_side u_adr_far_side (.clk(clk_sys), .rst_n(reset_n), .slow(slow),
        .xfer_req(xreq), .wake_req(wake), .xfer_done(xdone), .clock_running(running));

    always @(posedge clk_sys)
    begin
        if (xdone === 1'b1)
            done_cnt <= done_cnt + 1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // --------------------------------------------------------------
    // one trigger, held well past its transfer
    // --------------------------------------------------------------
    task automatic run(input row_s r);
        logic saw_p;
        logic saw_w;
        logic saw_b;
        int n0;
        saw_p = 1'b0;
        saw_w = 1'b0;
        saw_b = 1'b0;
        @(posedge clk_sys) cfg.chan_enable <= 1'b0;
        @(posedge clk_sys) cfg <= '{1'b1, r.aen, 1'b1, 1'b0, r.src, r.tsel};
        @(posedge clk_sys) gated <= r.gated;
        n0 = done_cnt;
        @(posedge clk_sys) preq <= adr_pkg::periph_req_s'(r.req);
        for (int i = 0; i < 40 && !(done_cnt != n0 && lp_ok === 1'b1); i++)
        begin
            @(posedge clk_sys);
            #1;
            saw_p |= pend;
            saw_w |= wake;
            saw_b |= busy;
        end
        repeat (8) @(posedge clk_sys);
        preq <= '0;
        repeat (3) @(posedge clk_sys);
        check(16'(done_cnt - n0), {15'h0, r.exp1});
        check({15'h0, saw_p}, {15'h0, r.exp1});
        check({15'h0, saw_w}, {15'h0, r.exp1 & r.gated});
        check({15'h0, saw_b}, {15'h0, r.exp1});
        check({15'h0, lp_ok}, 16'h1);
        if (r.exp1 && done_cnt == n0)
            tally_and_finish();
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial
    begin
        int n;
        reset_n = 1'b0;
        gated = 1'b0;
        slow = 1'b0;
        cfg = '0;
        preq = '0;
        repeat (3) @(posedge clk_sys);
        check({11'h0, xreq, wake, pend, busy, lp_ok}, 16'h1);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        check({11'h0, xreq, wake, pend, busy, lp_ok}, 16'h1);
        for (int k = 0; k < 14; k++)
        begin
            @(posedge clk_sys) slow <= k[0];
            run(rows[k]);
        end
        // short low gap between two triggers must give two transfers
        n = done_cnt;
        @(posedge clk_sys) preq <= adr_pkg::periph_req_s'(14'h2000);
        repeat (14) @(posedge clk_sys);
        preq <= '0;
        @(posedge clk_sys) preq <= adr_pkg::periph_req_s'(14'h2000);
        repeat (14) @(posedge clk_sys);
        preq <= '0;
        check(16'(done_cnt - n), 16'h2);
        // level mode keeps transferring while the request stays high
        n = done_cnt;
        @(posedge clk_sys) cfg.cycle_steal <= 1'b0;
        @(posedge clk_sys) preq <= adr_pkg::periph_req_s'(14'h2000);
        repeat (30) @(posedge clk_sys);
        preq <= '0;
        repeat (12) @(posedge clk_sys);
        cfg.cycle_steal <= 1'b1;
        check({15'h0, (done_cnt - n) > 1}, 16'h1);
        // reset in mid-transfer drops everything at once
        @(posedge clk_sys) preq <= adr_pkg::periph_req_s'(14'h2000);
        for (int i = 0; i < 20 && xreq !== 1'b1; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
        check({15'h0, xreq}, 16'h1);
        @(posedge clk_sys) reset_n <= 1'b0;
        #1;
        check({11'h0, xreq, wake, pend, busy, lp_ok}, 16'h1);
        @(posedge clk_sys) preq <= '0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        // quiet after release, then a fresh trigger is served
        @(posedge clk_sys);
        #1;
        check({11'h0, xreq, wake, pend, busy, lp_ok}, 16'h1);
        n = done_cnt;
        @(posedge clk_sys) preq <= adr_pkg::periph_req_s'(14'h2000);
        for (int i = 0; i < 30 && done_cnt == n; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
        preq <= '0;
        check(16'(done_cnt - n), 16'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
